// file: hdl/dbsc_brake_stop.sv
// Function
// - large drive: 4% becomes 2% on constant-torque
// - 2% returns to 4% on standard motor
// - braking current held within rated current
// - selection 0 ignores special duty setting
// - selection 0..2, duty 0..30%, default 0
// - selection 2: converter ready coasts, release restarts with search
// - run enable terminal code 10 shuts output
// - alarm at 85% of duty limit
// - overvoltage fault at 100% of limit
// - duty alarm alone never stops output
// - alarm terminal codes 7 high, 107 low
// - 0..100 s: coast after delay, fwd/rev starts
// - 1000..1100: start/direction, delay setting minus 1000
// - 9999 or 8888: decelerate on start release
// - running indication drops with output shutoff
// - bypass conditions override stop method
// - frequency command followed in run and stop delay, not during decel
// - restart from a coast not caused by converter loss uses starting frequency
`include "dbsc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module dbsc_brake_stop
   import dbsc_pkg::*;
#(
   parameter int unsigned SEC_CYCLES = `DBSC_SEC_NS / `DBSC_CLK_NS
) (
   input wire logic clk_sys, // 40 MHz clock
   input wire logic reset, // synchronous, active high
   input wire logic wb_cyc_i, // wishbone cycle
   input wire logic wb_stb_i, // wishbone strobe
   input wire logic wb_we_i, // wishbone write
   input wire logic [7:0] wb_adr_i, // byte address
   input wire logic [3:0] wb_sel_i, // byte lanes
   input wire logic [31:0] wb_dat_i, // write data
   output logic [31:0] wb_dat_o, // read data
   output logic wb_ack_o, // wishbone acknowledge
   input wire logic forward_start_input, // pin, forward / start
   input wire logic reverse_start_input, // pin, reverse / direction
   input wire logic [4:0] terminalIn, // pins, assignable inputs
   input wire logic converter_ready_line_b, // pin, high on supply loss
   input wire dbsc_bypass_t bypass, // stop-method overrides
   input wire logic decelDone, // motor reached zero during decel
   input wire logic [11:0] motorCurrent, // measured output current
   input wire logic [11:0] ratedCurrent, // rated drive current
   input wire logic [9:0] regenDuty, // accumulated duty, 0.1% units
   output dbsc_cmd_t driveCmd, // commands to modulator
   output logic runningOut, // running indication
   output logic startFromBase, // pulse: start at starting_frequency
   output logic speedSearch, // pulse: restart with speed detection
   output logic [4:0] brakeVoltageCmd, // applied brake voltage, %
   output logic brakeCurrentLimit, // brake torque being limited
   output logic regen_overvoltage_fault, // sticky trip
   output logic regen_duty_warning_display, // panel warning
   output logic [1:0] termOut // assignable output terminals
);
   // settings
   logic [4:0] dc_brake_voltage_pct_r;
   logic [5:0] applied_motor_select_r;
   logic [1:0] regen_function_select_r;
   logic [4:0] regen_duty_limit_r;
   logic [13:0] stop_method_select_r;
   logic [34:0] input_terminal_select_r;
   logic [7:0] output_terminal_select_a_r;
   logic [7:0] output_terminal_select_b_r;
   logic largeDrive_r;
   // state
   dbsc_state_t state_r, state_nxt;
   logic [31:0] preCnt_r;
   logic [6:0] secCnt_r;
   logic convLoss_r;
   logic ackReg_r;
   logic [31:0] rdData_r;
   logic [1:0] fwdSync_r, revSync_r, convSync_r;
   logic [4:0] termSync0_r, termSync1_r;
   logic fault_r, alarm_r;
   logic [1:0] termOut_r;
   logic [4:0] brakeCmd_r;
   logic limit_r;
   logic startPulse_r, searchPulse_r;
   dbsc_cmd_t cmd_r;
   logic running_r;
   // pin synchronisers, first stage read only by second
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         fwdSync_r <= 2'h0;
         revSync_r <= 2'h0;
         convSync_r <= 2'h0;
         termSync0_r <= 5'h00;
         termSync1_r <= 5'h00;
      end else begin
         fwdSync_r <= {fwdSync_r[0], forward_start_input};
         revSync_r <= {revSync_r[0], reverse_start_input};
         convSync_r <= {convSync_r[0], converter_ready_line_b};
         termSync0_r <= terminalIn;
         termSync1_r <= termSync0_r;
      end
   end
   wire logic fwdIn = fwdSync_r[1];
   wire logic revIn = revSync_r[1];
   // bus decode
   wire logic busReq = wb_cyc_i & wb_stb_i & ~ackReg_r;
   wire logic wrReq = busReq & wb_we_i;
   wire logic selBrake = wb_adr_i == `DBSC_OFS_BRAKE;
   wire logic selMotor = wb_adr_i == `DBSC_OFS_MOTOR;
   wire logic selRegen = wb_adr_i == `DBSC_OFS_REGEN;
   wire logic selStop = wb_adr_i == `DBSC_OFS_STOP;
   wire logic selIn0 = wb_adr_i == `DBSC_OFS_INSEL0;
   wire logic selIn1 = wb_adr_i == `DBSC_OFS_INSEL1;
   wire logic selOut = wb_adr_i == `DBSC_OFS_OUTSEL;
   wire logic selCtrl = wb_adr_i == `DBSC_OFS_CTRL;
   wire logic selStat = wb_adr_i == `DBSC_OFS_STATUS;
   wire logic [4:0] wrPct = wb_dat_i[4:0];
   wire logic [5:0] wrMotor = wb_dat_i[5:0];
   wire logic [1:0] wrRegSel = wb_dat_i[1:0];
   wire logic [4:0] wrRegLim = wb_dat_i[`DBSC_REGEN_LIM_LSB +: 5];
   wire logic [13:0] wrStop = wb_dat_i[13:0];
   wire logic fltClear = wrReq & selCtrl & wb_sel_i[0] & wb_dat_i[`DBSC_CTRL_FCLR_BIT];
   // motor class of old and new applied motor codes
   function automatic logic isStd(input logic [5:0] c);
      isStd = (c == 6'd0) | (c == 6'd3) | (c == 6'd23) | (c == 6'd40) | (c == 6'd43);
   endfunction
   function automatic logic isCt(input logic [5:0] c);
      isCt = (c == 6'd1) | (c == 6'd13) | (c == 6'd50) | (c == 6'd53);
   endfunction
   wire logic motorWr = wrReq & selMotor & wb_sel_i[0];
   wire logic toCt = motorWr & largeDrive_r & isStd(applied_motor_select_r) & isCt(wrMotor)
      & (dc_brake_voltage_pct_r == `DBSC_PCT_STD);
   wire logic toStd = motorWr & isCt(applied_motor_select_r) & isStd(wrMotor)
      & (dc_brake_voltage_pct_r == `DBSC_PCT_CT);
   // stop setting validity; out-of-range writes are dropped
   wire logic stopA = wrStop <= `DBSC_STOP_TMAX_A;
   wire logic stopB = (wrStop >= `DBSC_STOP_B_LO) & (wrStop <= `DBSC_STOP_B_HI);
   wire logic stopOk = stopA | stopB | (wrStop == `DBSC_STOP_DECEL_A) | (wrStop == `DBSC_STOP_DECEL_B);
   // setting registers
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         dc_brake_voltage_pct_r <= `DBSC_RST_BRAKE;
         applied_motor_select_r <= `DBSC_RST_MOTOR;
         regen_function_select_r <= `DBSC_RST_REGSEL;
         regen_duty_limit_r <= `DBSC_RST_REGLIM;
         stop_method_select_r <= `DBSC_RST_STOP;
         input_terminal_select_r <= {5{`DBSC_RST_INSEL}};
         output_terminal_select_a_r <= `DBSC_RST_OUTSEL;
         output_terminal_select_b_r <= `DBSC_RST_OUTSEL;
         largeDrive_r <= 1'b0;
      end else begin
         if (toCt) begin
            dc_brake_voltage_pct_r <= `DBSC_PCT_CT;
         end else if (toStd) begin
            dc_brake_voltage_pct_r <= `DBSC_PCT_STD;
         end else if (wrReq & selBrake & wb_sel_i[0] & (wrPct <= `DBSC_PCT_MAX)) begin
            dc_brake_voltage_pct_r <= wrPct;
         end
         if (motorWr) begin
            applied_motor_select_r <= wrMotor;
         end
         if (wrReq & selRegen & wb_sel_i[0] & (wrRegSel <= `DBSC_REGSEL_MAX)) begin
            regen_function_select_r <= wrRegSel;
         end
         if (wrReq & selRegen & wb_sel_i[1] & (wrRegLim <= `DBSC_DUTY_MAX)) begin
            regen_duty_limit_r <= wrRegLim;
         end
         if (wrReq & selStop & (&wb_sel_i[1:0]) & stopOk) begin
            stop_method_select_r <= wrStop;
         end
         for (int i = 0; i < 4; i++) begin
            if (wrReq & selIn0 & wb_sel_i[i]) begin
               input_terminal_select_r[7*i +: 7] <= wb_dat_i[8*i +: 7];
            end
         end
         if (wrReq & selIn1 & wb_sel_i[0]) begin
            input_terminal_select_r[34:28] <= wb_dat_i[6:0];
         end
         if (wrReq & selOut & wb_sel_i[0]) begin
            output_terminal_select_a_r <= wb_dat_i[7:0];
         end
         if (wrReq & selOut & wb_sel_i[1]) begin
            output_terminal_select_b_r <= wb_dat_i[15:8];
         end
         if (wrReq & selCtrl & wb_sel_i[0]) begin
            largeDrive_r <= wb_dat_i[`DBSC_CTRL_LARGE_BIT];
         end
      end
   end
   // assignable input terminals: run enable and output stop
   logic [4:0] isRunEn, isOutStop;
   genvar g;
   generate
      for (g = 0; g < 5; g++) begin : gTerm
         assign isRunEn[g] = input_terminal_select_r[7*g +: 7] == `DBSC_IN_RUNEN;
         assign isOutStop[g] = input_terminal_select_r[7*g +: 7] == `DBSC_IN_OUTSTOP;
      end
   endgenerate
   wire logic runEnOff = |(isRunEn & ~termSync1_r);
   wire logic outStopOn = |(isOutStop & termSync1_r);
   wire logic convIn = (regen_function_select_r == `DBSC_REGSEL_HC) & convSync_r[1];
   wire logic inhibit = runEnOff | outStopOn | convIn | fault_r;
   // duty limit in force; selection 0 uses the fixed drive duty
   wire logic [4:0] limitEff = (regen_function_select_r == 2'h0)
      ? (largeDrive_r ? `DBSC_DUTY_LARGE : `DBSC_DUTY_SMALL) : regen_duty_limit_r;
   wire logic [11:0] duty2 = {1'b0, regenDuty, 1'b0};
   wire logic [11:0] lim85 = 12'(limitEff * 5'd17);
   wire logic [10:0] lim100 = 11'(limitEff * 4'd10);
   wire logic limSet = limitEff != 5'h00;
   wire logic alarmNow = limSet & (duty2 >= lim85);
   wire logic faultNow = limSet & ({1'b0, regenDuty} >= lim100);
   // start decoding per stop method; 9999 lies above the timed range and keeps separate starts
   wire logic modeB = (stop_method_select_r == `DBSC_STOP_DECEL_B)
      | ((stop_method_select_r >= `DBSC_STOP_B_LO) & (stop_method_select_r <= `DBSC_STOP_B_HI));
   wire logic decelSel = (stop_method_select_r == `DBSC_STOP_DECEL_A)
      | (stop_method_select_r == `DBSC_STOP_DECEL_B);
   wire logic startOn = modeB ? fwdIn : (fwdIn ^ revIn);
   wire logic bypassAny = |bypass;
   wire logic [13:0] delayRaw = modeB ? (stop_method_select_r - `DBSC_STOP_B_LO) : stop_method_select_r;
   wire logic [6:0] delaySec = delayRaw[6:0];
   wire logic secTick = preCnt_r == 32'(SEC_CYCLES - 1);
   wire logic expired = secCnt_r == delaySec;
   // stop sequencing
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         DBSC_IDLE: begin
            if (startOn & ~inhibit) begin
               state_nxt = DBSC_RUN;
            end
         end
         DBSC_RUN: begin
            if (inhibit) begin
               state_nxt = DBSC_COAST;
            end else if (~startOn) begin
               state_nxt = (decelSel | bypassAny) ? DBSC_DECEL : DBSC_DELAY;
            end
         end
         DBSC_DELAY: begin
            if (inhibit | expired) begin
               state_nxt = DBSC_COAST;
            end else if (startOn) begin
               state_nxt = DBSC_RUN;
            end else if (bypassAny) begin
               state_nxt = DBSC_DECEL;
            end
         end
         DBSC_DECEL: begin
            if (inhibit) begin
               state_nxt = DBSC_COAST;
            end else if (startOn) begin
               state_nxt = DBSC_RUN;
            end else if (decelDone) begin
               state_nxt = DBSC_IDLE;
            end
         end
         DBSC_COAST: begin
            if (startOn & ~inhibit) begin
               state_nxt = DBSC_RUN;
            end
         end
         default: begin
            state_nxt = DBSC_IDLE;
         end
      endcase
   end
   wire logic outOnNxt = (state_nxt == DBSC_RUN) | (state_nxt == DBSC_DELAY) | (state_nxt == DBSC_DECEL);
   wire logic enterRun = (state_nxt == DBSC_RUN) & (state_r != DBSC_RUN) & (state_r != DBSC_DELAY)
      & (state_r != DBSC_DECEL);

   // state, stop timer and drive commands
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_r <= DBSC_IDLE;
         preCnt_r <= 32'h0;
         secCnt_r <= 7'h00;
         convLoss_r <= 1'b0;
         cmd_r <= '0;
         running_r <= 1'b0;
         startPulse_r <= 1'b0;
         searchPulse_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         if (state_r != DBSC_DELAY) begin
            preCnt_r <= 32'h0;
            secCnt_r <= 7'h00;
         end else if (secTick) begin
            preCnt_r <= 32'h0;
            secCnt_r <= secCnt_r + 7'h01;
         end else begin
            preCnt_r <= preCnt_r + 32'h1;
         end
         if (convIn & (state_r != DBSC_IDLE)) begin
            convLoss_r <= 1'b1;
         end else if (enterRun | (state_r == DBSC_IDLE)) begin
            convLoss_r <= 1'b0;
         end
         cmd_r.outputOn <= outOnNxt;
         cmd_r.followFreq <= (state_nxt == DBSC_RUN) | (state_nxt == DBSC_DELAY);
         cmd_r.decelToStop <= state_nxt == DBSC_DECEL;
         if (startOn) begin
            cmd_r.reverse <= revIn;
         end
         running_r <= outOnNxt;
         startPulse_r <= enterRun & ~convLoss_r;
         searchPulse_r <= enterRun & convLoss_r;
      end
   end

   // duty alarm, fault, brake voltage and output terminals
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         fault_r <= 1'b0;
         alarm_r <= 1'b0;
         termOut_r <= 2'h0;
         brakeCmd_r <= 5'h00;
         limit_r <= 1'b0;
      end else begin
         if (faultNow) begin
            fault_r <= 1'b1;
         end else if (fltClear) begin
            fault_r <= 1'b0;
         end
         alarm_r <= alarmNow;
         termOut_r[0] <= (output_terminal_select_a_r == `DBSC_OUT_ALM_POS) ? alarmNow
            : ((output_terminal_select_a_r == `DBSC_OUT_ALM_NEG) & ~alarmNow);
         termOut_r[1] <= (output_terminal_select_b_r == `DBSC_OUT_ALM_POS) ? alarmNow
            : ((output_terminal_select_b_r == `DBSC_OUT_ALM_NEG) & ~alarmNow);
         limit_r <= motorCurrent >= ratedCurrent;
         brakeCmd_r <= (motorCurrent >= ratedCurrent) ? 5'h00 : dc_brake_voltage_pct_r;
      end
   end

   // read data and acknowledge, one cycle after request
   wire logic [31:0] statWord = {24'h0, running_r, alarm_r, fault_r, convLoss_r, 1'b0, state_r};
   wire logic [31:0] rdMux =
      selBrake ? {27'h0, dc_brake_voltage_pct_r} :
      selMotor ? {26'h0, applied_motor_select_r} :
      selRegen ? {19'h0, regen_duty_limit_r, 6'h0, regen_function_select_r} :
      selStop ? {18'h0, stop_method_select_r} :
      selIn0 ? {1'b0, input_terminal_select_r[27:21], 1'b0, input_terminal_select_r[20:14],
                1'b0, input_terminal_select_r[13:7], 1'b0, input_terminal_select_r[6:0]} :
      selIn1 ? {25'h0, input_terminal_select_r[34:28]} :
      selOut ? {16'h0, output_terminal_select_b_r, output_terminal_select_a_r} :
      selCtrl ? {31'h0, largeDrive_r} :
      selStat ? statWord : 32'h0;
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ackReg_r <= 1'b0;
         rdData_r <= 32'h0;
      end else begin
         ackReg_r <= busReq;
         rdData_r <= (busReq & ~wb_we_i) ? rdMux : 32'h0;
      end
   end

   assign wb_ack_o = ackReg_r;
   assign wb_dat_o = rdData_r;
   assign driveCmd = cmd_r;
   assign runningOut = running_r;
   assign startFromBase = startPulse_r;
   assign speedSearch = searchPulse_r;
   assign brakeVoltageCmd = brakeCmd_r;
   assign brakeCurrentLimit = limit_r;
   assign regen_overvoltage_fault = fault_r;
   assign regen_duty_warning_display = alarm_r & (regen_function_select_r != 2'h0);
   assign termOut = termOut_r;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   // assertions
   ct_rewrite_a: assert property (toCt |=> dc_brake_voltage_pct_r == `DBSC_PCT_CT)
      else $error("brake voltage not set to constant-torque value");
   std_rewrite_a: assert property (toStd |=> dc_brake_voltage_pct_r == `DBSC_PCT_STD)
      else $error("brake voltage not restored to standard value");
   brake_limit_a: assert property (motorCurrent >= ratedCurrent |=> brakeVoltageCmd == 5'h00)
      else $error("brake voltage applied above rated current");
   run_enable_a: assert property (runEnOff & cmd_r.outputOn |=> !cmd_r.outputOn)
      else $error("output not shut off on run enable loss");
   duty_fault_a: assert property (faultNow |=> regen_overvoltage_fault)
      else $error("overvoltage fault missing at full duty");
   alarm_nostop_a: assert property (alarmNow & !faultNow & !inhibit & startOn & (state_r == DBSC_RUN)
      |=> cmd_r.outputOn)
      else $error("duty alarm stopped the output");
   run_follows_a: assert property (runningOut == driveCmd.outputOn)
      else $error("running indication differs from output state");
   decel_pick_a: assert property ((state_r == DBSC_RUN) & !startOn & !inhibit & decelSel
      |=> state_r == DBSC_DECEL)
      else $error("decelerating stop not taken");
   delay_cancel_a: assert property ((state_r == DBSC_DELAY) & startOn & !inhibit & !expired
      |=> state_r == DBSC_RUN ##1 secCnt_r == 7'h00)
      else $error("stop delay not cancelled by start");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held for more than one cycle");
endmodule
`default_nettype wire

// file: hdl/dbsc_params.svh
`ifndef DBSC_PARAMS_SVH
`define DBSC_PARAMS_SVH
// register byte offsets
`define DBSC_OFS_BRAKE 8'h00
`define DBSC_OFS_MOTOR 8'h04
`define DBSC_OFS_REGEN 8'h08
`define DBSC_OFS_STOP 8'h0c
`define DBSC_OFS_INSEL0 8'h10
`define DBSC_OFS_INSEL1 8'h14
`define DBSC_OFS_OUTSEL 8'h18
`define DBSC_OFS_CTRL 8'h1c
`define DBSC_OFS_STATUS 8'h20
// field positions
`define DBSC_REGEN_LIM_LSB 8
`define DBSC_CTRL_LARGE_BIT 0
`define DBSC_CTRL_FCLR_BIT 1
// reset values
`define DBSC_RST_BRAKE 5'h04
`define DBSC_RST_MOTOR 6'h00
`define DBSC_RST_REGSEL 2'h0
`define DBSC_RST_REGLIM 5'h00
`define DBSC_RST_STOP 14'h270f
`define DBSC_RST_INSEL 7'h00
`define DBSC_RST_OUTSEL 8'h00
// setting codes
`define DBSC_PCT_STD 5'h04
`define DBSC_PCT_CT 5'h02
`define DBSC_PCT_MAX 5'h1e
`define DBSC_DUTY_MAX 5'h1e
`define DBSC_DUTY_SMALL 5'h03
`define DBSC_DUTY_LARGE 5'h02
`define DBSC_REGSEL_MAX 2'h2
`define DBSC_REGSEL_HC 2'h2
`define DBSC_STOP_DECEL_A 14'h270f
`define DBSC_STOP_DECEL_B 14'h22b8
`define DBSC_STOP_TMAX_A 14'h0064
`define DBSC_STOP_B_LO 14'h03e8
`define DBSC_STOP_B_HI 14'h044c
`define DBSC_IN_RUNEN 7'h0a
`define DBSC_IN_OUTSTOP 7'h18
`define DBSC_OUT_ALM_POS 8'h07
`define DBSC_OUT_ALM_NEG 8'h6b
// timing: one second and the clock period, both in nanoseconds
`define DBSC_SEC_NS 1000000000
`define DBSC_CLK_NS 25
`endif

// file: hdl/dbsc_pkg.sv
package dbsc_pkg;
   typedef enum logic [2:0] {
      DBSC_IDLE = 3'b000,
      DBSC_RUN = 3'b001,
      DBSC_DELAY = 3'b010,
      DBSC_DECEL = 3'b011,
      DBSC_COAST = 3'b100
   } dbsc_state_t;
   // conditions that override the selected stop method
   typedef struct packed {
      logic powerFailStop;
      logic panelStop;
      logic commErrStop;
      logic jogMode;
   } dbsc_bypass_t;
   // drive commands towards the modulator
   typedef struct packed {
      logic outputOn;
      logic followFreq;
      logic decelToStop;
      logic reverse;
   } dbsc_cmd_t;
endpackage

// file: tb/dbsc_brake_stop_test.sv
`timescale 1ns/1ps
`default_nettype none
module dbsc_brake_stop_test
   import dbsc_pkg::*;
;
   localparam int SEC = 10;
   logic clk_sys = 1'b0, reset = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic ack, fwd = 1'b0, rev = 1'b0, lossCmd = 1'b0, cnvRdy, decelDone = 1'b0;
   logic [4:0] terminalIn = 5'h01;
   dbsc_bypass_t bypass = '0;
   logic [11:0] motorCurrent = 12'h000, ratedCurrent = 12'h100;
   logic [9:0] regenDuty = 10'h000;
   dbsc_cmd_t driveCmd;
   logic running, fromBase, search, curLim, fault, warn, sawBase, sawSearch;
   logic [4:0] brakeV;
   logic [1:0] termOut;
   int num_errors = 0, check_count = 0, cycles = 0, waitN;
   // design and converter model
   dbsc_brake_stop #(.SEC_CYCLES(SEC)) dut_u (.clk_sys(clk_sys), .reset(reset), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .forward_start_input(fwd), .reverse_start_input(rev), .terminalIn(terminalIn),
      .converter_ready_line_b(cnvRdy), .bypass(bypass), .decelDone(decelDone),
      .motorCurrent(motorCurrent), .ratedCurrent(ratedCurrent), .regenDuty(regenDuty),
      .driveCmd(driveCmd), .runningOut(running), .startFromBase(fromBase), .speedSearch(search),
      .brakeVoltageCmd(brakeV), .brakeCurrentLimit(curLim), .regen_overvoltage_fault(fault),
      .regen_duty_warning_display(warn), .termOut(termOut));
   dbsc_conv_model conv_u (.clk_sys(clk_sys), .lossCmd(lossCmd), .converter_ready_line_b(cnvRdy));
   // clock and hang guard
   initial begin
      forever #12.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         wrap_up();
      end
   end
   // compare and count
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // one classic wishbone cycle, held until ack
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hf;
      wdat <= d;
      @(posedge clk_sys);
      // ack or the bench timeout ends this wait, no local limit
      while (ack !== 1'b1) begin
         @(posedge clk_sys);
         n++;
      end
      chk("ackwait", n, 32'h1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk("rdata", q, exp);
   endtask
   // wait for running level, noting start pulses
   task automatic waitRun(input logic v);
      waitN = 0;
      sawBase = 1'b0;
      sawSearch = 1'b0;
      while (running !== v && waitN < 200) begin
         @(posedge clk_sys);
         waitN++;
         if (fromBase === 1'b1) sawBase = 1'b1;
         if (search === 1'b1) sawSearch = 1'b1;
      end
      chk("running", running, v);
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // reset values and refused writes
   task automatic t_regs();
      rd(8'h00, 32'h4);
      rd(8'h0c, 32'h270f);
      rd(8'h40, 32'h0);
      bus(1'b1, 8'h08, 32'h3);
      rd(8'h08, 32'h0);
   endtask
   // brake voltage follows motor class, current limit zeroes it
   task automatic t_motor();
      bus(1'b1, 8'h1c, 32'h1);
      bus(1'b1, 8'h04, 32'h1);
      rd(8'h00, 32'h2);
      bus(1'b1, 8'h04, 32'h3);
      rd(8'h00, 32'h4);
      motorCurrent <= 12'h100;
      repeat (4) @(posedge clk_sys);
      chk("curLim", curLim, 1'b1);
      chk("brakeV", brakeV, 5'h0);
      motorCurrent <= 12'h000;
   endtask
   // reverse start, decelerate on release
   task automatic t_decel();
      rev <= 1'b1;
      waitRun(1'b1);
      chk("reverse", driveCmd.reverse, 1'b1);
      rev <= 1'b0;
      repeat (5) @(posedge clk_sys);
      chk("decel", driveCmd.decelToStop, 1'b1);
      decelDone <= 1'b1;
      waitRun(1'b0);
      decelDone <= 1'b0;
   endtask
   // timed coast, cancel on restart, restart from base
   task automatic t_delay();
      bus(1'b1, 8'h0c, 32'h2);
      fwd <= 1'b1;
      waitRun(1'b1);
      fwd <= 1'b0;
      repeat (8) @(posedge clk_sys);
      chk("follow", driveCmd.followFreq, 1'b1);
      fwd <= 1'b1;
      repeat (30) @(posedge clk_sys);
      chk("running", running, 1'b1);
      fwd <= 1'b0;
      waitRun(1'b0);
      chk("delay", waitN >= 2 * SEC + 1 && waitN <= 2 * SEC + 8, 1'b1);
      chk("outOn", driveCmd.outputOn, 1'b0);
      bus(1'b1, 8'h0c, 32'h3e9);
      fwd <= 1'b1;
      rev <= 1'b1;
      waitRun(1'b1);
      chk("base", sawBase, 1'b1);
      chk("reverse", driveCmd.reverse, 1'b1);
      fwd <= 1'b0;
      waitRun(1'b0);
      chk("delay", waitN >= SEC + 1 && waitN <= SEC + 8, 1'b1);
      rev <= 1'b0;
   endtask
   // run enable withdrawn shuts output
   task automatic t_runEn();
      bus(1'b1, 8'h10, 32'h180a);
      fwd <= 1'b1;
      waitRun(1'b1);
      terminalIn <= 5'h00;
      waitRun(1'b0);
      terminalIn <= 5'h01;
      waitRun(1'b1);
      terminalIn <= 5'h03;
      waitRun(1'b0);
      fwd <= 1'b0;
      terminalIn <= 5'h01;
      bus(1'b1, 8'h10, 32'h0);
   endtask
   // duty alarm at 85 percent, trip at 100 percent
   task automatic t_duty();
      bus(1'b1, 8'h08, 32'h0a01);
      bus(1'b1, 8'h18, 32'h6b07);
      fwd <= 1'b1;
      waitRun(1'b1);
      regenDuty <= 10'd84;
      repeat (4) @(posedge clk_sys);
      chk("termOut", termOut, 2'b10);
      regenDuty <= 10'd85;
      repeat (4) @(posedge clk_sys);
      chk("termOut", termOut, 2'b01);
      chk("warn", warn, 1'b1);
      chk("running", running, 1'b1);
      regenDuty <= 10'd100;
      waitRun(1'b0);
      chk("fault", fault, 1'b1);
      fwd <= 1'b0;
      regenDuty <= 10'd0;
      bus(1'b1, 8'h1c, 32'h3);
      bus(1'b1, 8'h08, 32'h0a00);
      regenDuty <= 10'd17;
      repeat (4) @(posedge clk_sys);
      chk("termOut", termOut, 2'b01);
      chk("warn", warn, 1'b0);
      regenDuty <= 10'd0;
   endtask
   // converter supply loss coasts, release restarts with search
   task automatic t_conv();
      bus(1'b1, 8'h08, 32'h2);
      fwd <= 1'b1;
      waitRun(1'b1);
      lossCmd <= 1'b1;
      waitRun(1'b0);
      lossCmd <= 1'b0;
      waitRun(1'b1);
      chk("search", sawSearch, 1'b1);
      fwd <= 1'b0;
   endtask
   // bypass forces a decelerating stop; 8888 uses start and direction
   task automatic t_bypass();
      bypass.jogMode <= 1'b1;
      fwd <= 1'b1;
      waitRun(1'b1);
      fwd <= 1'b0;
      repeat (5) @(posedge clk_sys);
      chk("bypass", driveCmd.decelToStop, 1'b1);
      bypass.jogMode <= 1'b0;
      decelDone <= 1'b1;
      waitRun(1'b0);
      decelDone <= 1'b0;
      bus(1'b1, 8'h0c, 32'h22b8);
      fwd <= 1'b1;
      rev <= 1'b1;
      waitRun(1'b1);
      chk("reverse", driveCmd.reverse, 1'b1);
      fwd <= 1'b0;
      repeat (5) @(posedge clk_sys);
      chk("decel", driveCmd.decelToStop, 1'b1);
      decelDone <= 1'b1;
      rev <= 1'b0;
      waitRun(1'b0);
      decelDone <= 1'b0;
   endtask
   // main sequence
   initial begin
      repeat (16) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      t_regs();
      t_motor();
      t_decel();
      t_delay();
      t_runEn();
      t_bypass();
      t_duty();
      t_conv();
      wrap_up();
   end
endmodule
`default_nettype wire

// file: tb/dbsc_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
// converter side: ready line reports supply loss on command
module dbsc_conv_model (
   input wire logic clk_sys, // system clock
   input wire logic lossCmd, // bench asks for a supply loss
   output logic converter_ready_line_b = 1'b0 // high while supply is lost
);
   // raise on loss, release after restoration
   always_ff @(posedge clk_sys) begin
      converter_ready_line_b <= lossCmd;
   end
endmodule
`default_nettype wire
